// File: logic/sfcd_defines.svh
// constants for the serial flash command decoder
// assumes inclusion by bare name from logic/
`ifndef SFCD_DEFINES_SVH
`define SFCD_DEFINES_SVH
`define SFCD_OP_SIG_WAKE   8'hAB
`define SFCD_OP_STD_ID     8'h9F
`define SFCD_OP_MAKER_DEV  8'h90
`define SFCD_OP_READ       8'h03
`define SFCD_OP_FAST_READ  8'h0B
`define SFCD_OP_FR2_OUT    8'h3B
`define SFCD_OP_FR2_IO     8'hBB
`define SFCD_OP_FR4_OUT    8'h6B
`define SFCD_OP_FR4_IO     8'hEB
`define SFCD_OP_PAGE_WR    8'h02
`define SFCD_OP_PAGE_WR2   8'hA2
`define SFCD_OP_PAGE_WR4   8'h32
`define SFCD_OP_SUSP_A     8'h75
`define SFCD_OP_SUSP_B     8'hB0
`define SFCD_OP_RESUME_A   8'h7A
`define SFCD_OP_RESUME_B   8'h30
`define SFCD_OP_OTP_WR     8'hB1
`define SFCD_OP_OTP_RD     8'h4B
`define SFCD_BYTES_1       3'h1
`define SFCD_BYTES_2       3'h2
`define SFCD_BYTES_3       3'h3
`define SFCD_BYTES_4       3'h4
`define SFCD_BYTES_5       3'h5
`define SFCD_PAGE_DATA     9'h100
`define SFCD_BIT_LAST      3'h7
`define SFCD_BIT_FIRST     3'h0
`define SFCD_SIG_DUMMY     2'h3
`define SFCD_WAKE_DELAY_NS 3000
`define SFCD_CLK_NS        40
`define SFCD_ZERO8         8'h00
`endif

// File: logic/sfcd_opdecode.sv
// opcode classifier: command kind and byte counts
// assumes a complete opcode byte at its input
`timescale 1ns/1ps
`include "sfcd_defines.svh"
module sfcd_opdecode (
  input  wire logic [7:0]    opcode,
  output sfcd_pkg::sfcd_decode_t dec
);
  import sfcd_pkg::*;
  always_comb begin
    dec = '{cmd: SFCD_CMD_NONE, cmd_bytes: `SFCD_BYTES_1, has_data: 1'b0, slow_clock: 1'b0};
    case (opcode)
      `SFCD_OP_SIG_WAKE:  dec = '{SFCD_CMD_SIG, `SFCD_BYTES_4, 1'b0, 1'b0};
      `SFCD_OP_STD_ID:    dec = '{SFCD_CMD_STD_ID, `SFCD_BYTES_1, 1'b0, 1'b0};
      `SFCD_OP_MAKER_DEV: dec = '{SFCD_CMD_MAKER, `SFCD_BYTES_4, 1'b0, 1'b0};
      `SFCD_OP_READ:      dec = '{SFCD_CMD_READ, `SFCD_BYTES_4, 1'b0, 1'b1};
      `SFCD_OP_FAST_READ: dec = '{SFCD_CMD_FAST, `SFCD_BYTES_5, 1'b0, 1'b0};
      `SFCD_OP_FR2_OUT:   dec = '{SFCD_CMD_FR2_OUT, `SFCD_BYTES_5, 1'b0, 1'b0};
      `SFCD_OP_FR2_IO:    dec = '{SFCD_CMD_FR2_IO, `SFCD_BYTES_3, 1'b0, 1'b0};
      `SFCD_OP_FR4_OUT:   dec = '{SFCD_CMD_FR4_OUT, `SFCD_BYTES_5, 1'b0, 1'b0};
      `SFCD_OP_FR4_IO:    dec = '{SFCD_CMD_FR4_IO, `SFCD_BYTES_2, 1'b0, 1'b0};
      `SFCD_OP_PAGE_WR:   dec = '{SFCD_CMD_PAGE_WR, `SFCD_BYTES_4, 1'b1, 1'b0};
      `SFCD_OP_PAGE_WR2:  dec = '{SFCD_CMD_PAGE_WR2, `SFCD_BYTES_4, 1'b1, 1'b0};
      `SFCD_OP_PAGE_WR4:  dec = '{SFCD_CMD_PAGE_WR4, `SFCD_BYTES_4, 1'b1, 1'b0};
      `SFCD_OP_SUSP_A,
      `SFCD_OP_SUSP_B:    dec = '{SFCD_CMD_SUSPEND, `SFCD_BYTES_1, 1'b0, 1'b0};
      `SFCD_OP_RESUME_A,
      `SFCD_OP_RESUME_B:  dec = '{SFCD_CMD_RESUME, `SFCD_BYTES_1, 1'b0, 1'b0};
      `SFCD_OP_OTP_WR:    dec = '{SFCD_CMD_OTP_WR, `SFCD_BYTES_4, 1'b0, 1'b0};
      `SFCD_OP_OTP_RD:    dec = '{SFCD_CMD_OTP_RD, `SFCD_BYTES_4, 1'b0, 1'b1};
      default:            dec = '{SFCD_CMD_NONE, `SFCD_BYTES_1, 1'b0, 1'b0};
    endcase
  end
endmodule

// File: logic/sfcd_pkg.sv
// types for the serial flash command decoder
// assumes the defines header is compiled alongside
package sfcd_pkg;
  typedef enum logic [4:0] {
    SFCD_CMD_NONE     = 5'b00000,
    SFCD_CMD_SIG      = 5'b00001,
    SFCD_CMD_STD_ID   = 5'b00010,
    SFCD_CMD_MAKER    = 5'b00011,
    SFCD_CMD_READ     = 5'b00100,
    SFCD_CMD_FAST     = 5'b00101,
    SFCD_CMD_FR2_OUT  = 5'b00110,
    SFCD_CMD_FR2_IO   = 5'b00111,
    SFCD_CMD_FR4_OUT  = 5'b01000,
    SFCD_CMD_FR4_IO   = 5'b01001,
    SFCD_CMD_PAGE_WR  = 5'b01010,
    SFCD_CMD_PAGE_WR2 = 5'b01011,
    SFCD_CMD_PAGE_WR4 = 5'b01100,
    SFCD_CMD_SUSPEND  = 5'b01101,
    SFCD_CMD_RESUME   = 5'b01110,
    SFCD_CMD_OTP_WR   = 5'b01111,
    SFCD_CMD_OTP_RD   = 5'b10000
  } sfcd_cmd_t;

  typedef struct packed {
    sfcd_cmd_t   cmd;
    logic [2:0]  cmd_bytes;
    logic        has_data;
    logic        slow_clock;
  } sfcd_decode_t;

  typedef enum logic [2:0] {
    SFCD_ST_OPCODE = 3'b000,
    SFCD_ST_DUMMY  = 3'b001,
    SFCD_ST_SIGOUT = 3'b010,
    SFCD_ST_BODY   = 3'b011,
    SFCD_ST_IGNORE = 3'b100
  } sfcd_state_t;
endpackage

// File: logic/sfcd_sync.sv
// two flip-flop level synchroniser
// assumes d comes from another clock domain
`timescale 1ns/1ps
module sfcd_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// File: logic/sfcd_top.sv
// serial flash instruction front end: opcode capture, hold, signature read, wake
// assumes spi_clk is the host clock, spi_cs_n high between commands
`timescale 1ns/1ps
`include "sfcd_defines.svh"
module sfcd_top #(
  parameter logic [7:0] SIGNATURE_BYTE   = 8'h5A, // arbitrary value
  parameter int         WAKE_DELAY_CYCLES =
    (`SFCD_WAKE_DELAY_NS + `SFCD_CLK_NS - 1) / `SFCD_CLK_NS
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 spi_clk,
  input  wire logic                 spi_cs_n,
  input  wire logic                 spi_si,
  input  wire logic                 hold_n,
  input  wire logic                 array_busy,
  input  wire logic                 deep_power_down,
  output logic                      spi_so_o,
  output logic                      spi_so_oe_n,
  output logic                      write_busy_flag,
  output logic                      wake_done,
  output logic                      cmd_valid,
  output sfcd_pkg::sfcd_decode_t    cmd_info,
  output logic                      ready
);
  import sfcd_pkg::*;

  // ---------------- link domain (spi_clk) ----------------
  sfcd_state_t  state_reg;
  logic [7:0]   shift_reg;
  logic [2:0]   bit_reg;
  logic [1:0]   dummy_reg;
  logic [7:0]   sig_sh_reg;
  logic [2:0]   sig_bit_reg;
  logic         so_reg;
  logic         so_en_reg;
  logic         cmd_tgl_reg;
  logic         wake_tgl_reg;
  logic         hold_act_reg;
  logic         cmd_take;
  sfcd_decode_t dec_now;
  sfcd_decode_t cap_reg;
  logic         busy_lk_m;
  logic         busy_lk;
  logic         blocked_lk_m;
  logic         blocked_lk;
  logic [7:0]   opcode_now;
  logic         paused;

  assign opcode_now = {shift_reg[6:0], spi_si};
  // hold is steady around every rising edge, so it pauses that very edge
  assign paused     = ~hold_n;
  assign cmd_take   = !spi_cs_n && !paused && state_reg == SFCD_ST_OPCODE &&
                      bit_reg == `SFCD_BIT_LAST && !blocked_lk &&
                      dec_now.cmd != SFCD_CMD_NONE &&
                      !(dec_now.cmd == SFCD_CMD_SIG && busy_lk);

  sfcd_opdecode u_dec (
    .opcode (opcode_now),
    .dec    (dec_now)
  );

  // hold is taken on falling clock edges; host changes it only while clock is low
  always_ff @(negedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      hold_act_reg <= 1'b0;
    end else begin
      hold_act_reg <= ~hold_n;
    end
  end

  // busy and wake block brought into the link clock
  always_ff @(posedge spi_clk or posedge reset) begin
    if (reset) begin
      busy_lk_m    <= 1'b0;
      busy_lk      <= 1'b0;
      blocked_lk_m <= 1'b0;
      blocked_lk   <= 1'b0;
    end else begin
      busy_lk_m    <= write_busy_flag;
      busy_lk      <= busy_lk_m;
      blocked_lk_m <= ~ready;
      blocked_lk   <= blocked_lk_m;
    end
  end

  // opcode capture and sequence, cleared by chip select high
  always_ff @(posedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      state_reg    <= SFCD_ST_OPCODE;
      shift_reg    <= `SFCD_ZERO8;
      bit_reg      <= `SFCD_BIT_FIRST;
      dummy_reg    <= 2'h0;
    end else if (!paused) begin
      shift_reg <= opcode_now;
      bit_reg   <= bit_reg + 3'h1;
      case (state_reg)
        SFCD_ST_OPCODE: begin
          if (bit_reg == `SFCD_BIT_LAST) begin
            if (blocked_lk) begin
              state_reg <= SFCD_ST_IGNORE;
            end else if (dec_now.cmd == SFCD_CMD_NONE) begin
              state_reg <= SFCD_ST_IGNORE;
            end else if (dec_now.cmd == SFCD_CMD_SIG) begin
              state_reg <= busy_lk ? SFCD_ST_IGNORE : SFCD_ST_DUMMY;
            end else begin
              state_reg <= SFCD_ST_BODY;
            end
          end
        end
        SFCD_ST_DUMMY: begin
          if (bit_reg == `SFCD_BIT_LAST) begin
            dummy_reg <= dummy_reg + 2'h1;
            if (dummy_reg == `SFCD_SIG_DUMMY - 2'h1) begin
              state_reg <= SFCD_ST_SIGOUT;
            end
          end
        end
        SFCD_ST_SIGOUT: state_reg <= SFCD_ST_SIGOUT;
        SFCD_ST_BODY:   state_reg <= SFCD_ST_BODY;
        SFCD_ST_IGNORE: state_reg <= SFCD_ST_IGNORE;
        default:        state_reg <= SFCD_ST_IGNORE;
      endcase
    end
  end

  // toggles mark a decoded command and a wake sequence
  always_ff @(posedge spi_clk or posedge reset) begin
    if (reset) begin
      cmd_tgl_reg <= 1'b0;
    end else if (cmd_take) begin
      cmd_tgl_reg <= ~cmd_tgl_reg;
    end
  end

  // decode word kept past select high so the slow side can copy it
  always_ff @(posedge spi_clk or posedge reset) begin
    if (reset) begin
      cap_reg <= '{SFCD_CMD_NONE, `SFCD_BYTES_1, 1'b0, 1'b0};
    end else if (cmd_take) begin
      cap_reg <= dec_now;
    end
  end

  // wake armed when a full ABh opcode is in while not busy or blocked, dropped on the next clock; fired if select rises
  logic wake_arm_reg;
  always_ff @(posedge spi_clk or posedge reset) begin
    if (reset) begin
      wake_arm_reg <= 1'b0;
    end else if (!spi_cs_n && !paused && state_reg == SFCD_ST_OPCODE &&
                 bit_reg == `SFCD_BIT_LAST) begin
      wake_arm_reg <= (dec_now.cmd == SFCD_CMD_SIG) && !busy_lk && !blocked_lk;
    end else if (!spi_cs_n && !paused) begin
      wake_arm_reg <= 1'b0;
    end
  end

  always_ff @(posedge spi_cs_n or posedge reset) begin
    if (reset) begin
      wake_tgl_reg <= 1'b0;
    end else if (wake_arm_reg) begin
      wake_tgl_reg <= ~wake_tgl_reg;
    end
  end

  // signature output, changing on falling edges, msb first
  always_ff @(negedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      sig_sh_reg  <= `SFCD_ZERO8;
      sig_bit_reg <= `SFCD_BIT_FIRST;
      so_reg      <= 1'b0;
      so_en_reg   <= 1'b0;
    end else if (!hold_n) begin
      so_en_reg <= 1'b0;
    end else if (state_reg == SFCD_ST_SIGOUT) begin
      so_en_reg   <= 1'b1;
      sig_bit_reg <= sig_bit_reg + 3'h1;
      if (sig_bit_reg == `SFCD_BIT_FIRST) begin
        so_reg     <= SIGNATURE_BYTE[7];
        sig_sh_reg <= {SIGNATURE_BYTE[6:0], 1'b0};
      end else begin
        so_reg     <= sig_sh_reg[7];
        sig_sh_reg <= {sig_sh_reg[6:0], 1'b0};
      end
    end else begin
      so_en_reg <= 1'b0;
    end
  end

  // ---------------- system domain (clk_sys) ----------------
  logic cmd_tgl_s;
  logic wake_tgl_s;
  logic cmd_tgl_d;
  logic cmd_edge_reg;
  logic wake_tgl_d;
  logic so_s;
  logic so_en_s;
  logic [$bits(sfcd_decode_t)-1:0] info_s;
  logic [15:0] wake_cnt_reg;

  sfcd_sync u_cmd_sync (.clk(clk_sys), .reset(reset), .d(cmd_tgl_reg), .q(cmd_tgl_s));
  sfcd_sync u_wake_sync (.clk(clk_sys), .reset(reset), .d(wake_tgl_reg), .q(wake_tgl_s));
  sfcd_sync u_so_sync (.clk(clk_sys), .reset(reset), .d(so_reg), .q(so_s));
  sfcd_sync u_oe_sync (.clk(clk_sys), .reset(reset), .d(so_en_reg), .q(so_en_s));

  // decode word is stable for a whole command before its toggle lands
  genvar gi;
  generate
    for (gi = 0; gi < $bits(sfcd_decode_t); gi++) begin : g_info
      sfcd_sync u_info_sync (
        .clk   (clk_sys),
        .reset (reset),
        .d     (cap_reg[gi]),
        .q     (info_s[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmd_tgl_d  <= 1'b0;
      cmd_edge_reg <= 1'b0;
      wake_tgl_d <= 1'b0;
      cmd_valid  <= 1'b0;
      cmd_info   <= '{SFCD_CMD_NONE, `SFCD_BYTES_1, 1'b0, 1'b0};
    end else begin
      cmd_tgl_d  <= cmd_tgl_s;
      wake_tgl_d <= wake_tgl_s;
      // one cycle of margin so every info bit has settled before the copy
      cmd_edge_reg <= cmd_tgl_s ^ cmd_tgl_d;
      cmd_valid  <= cmd_edge_reg;
      if (cmd_edge_reg) begin
        cmd_info <= sfcd_decode_t'(info_s);
      end
    end
  end

  // wake delay: commands refused until the count runs out
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wake_cnt_reg <= 16'h0000;
      ready        <= 1'b1;
      wake_done    <= 1'b0;
    end else begin
      wake_done <= 1'b0;
      if ((wake_tgl_s ^ wake_tgl_d) && deep_power_down) begin
        wake_cnt_reg <= WAKE_DELAY_CYCLES[15:0];
        ready        <= 1'b0;
      end else if (wake_cnt_reg != 16'h0000) begin
        wake_cnt_reg <= wake_cnt_reg - 16'h0001;
        if (wake_cnt_reg == 16'h0001) begin
          ready     <= 1'b1;
          wake_done <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      write_busy_flag <= 1'b0;
      spi_so_o        <= 1'b0;
      spi_so_oe_n     <= 1'b1;
    end else begin
      write_busy_flag <= array_busy;
      spi_so_o        <= so_s;
      spi_so_oe_n     <= ~so_en_s;
    end
  end

  // assertions
  property p_busy_follows;
    @(posedge clk_sys) disable iff (reset) array_busy |=> write_busy_flag;
  endproperty
  a_busy_follows: assert property (p_busy_follows) else $error("busy flag lost");

  property p_ready_clear;
    @(posedge clk_sys) disable iff (reset) !array_busy |=> !write_busy_flag;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("busy flag stuck");

  property p_wake_blocks;
    @(posedge clk_sys) disable iff (reset) $fell(ready) |-> !ready [*8];
  endproperty
  a_wake_blocks: assert property (p_wake_blocks) else $error("wake delay cut short");

  property p_done_ready;
    @(posedge clk_sys) disable iff (reset) wake_done |-> ready && !$past(ready);
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("wake done without delay");

  property p_valid_pulse;
    @(posedge clk_sys) disable iff (reset) cmd_valid |=> !cmd_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("command pulse too long");

  property p_info_known;
    @(posedge clk_sys) disable iff (reset) cmd_valid |-> cmd_info.cmd != SFCD_CMD_NONE;
  endproperty
  a_info_known: assert property (p_info_known) else $error("unknown opcode reported");

  property p_sig_needs_idle;
    @(posedge spi_clk) disable iff (reset || spi_cs_n)
      (state_reg == SFCD_ST_DUMMY) |-> !busy_lk || ($past(state_reg) == SFCD_ST_DUMMY);
  endproperty
  a_sig_needs_idle: assert property (p_sig_needs_idle) else $error("signature while busy");

  property p_hold_float;
    @(negedge spi_clk) disable iff (reset || spi_cs_n) hold_act_reg |-> !so_en_reg;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("output driven in hold");

  property p_hold_keep;
    @(posedge spi_clk) disable iff (reset || spi_cs_n)
      paused |=> $stable(shift_reg) && $stable(state_reg);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("sequence moved in hold");
endmodule

// File: verif/sfcd_host_model.sv
// spi host model driving select, serial clock, serial input and pause
// assumes the bench calls its tasks; clock stands low outside frames
`timescale 1ns/1ps
module sfcd_host_model (
  output logic      spi_clk,
  output logic      spi_cs_n,
  output logic      spi_si,
  output logic      hold_n,
  input  wire logic spi_so_o
);
  initial begin
    spi_clk  = 1'b0;
    spi_cs_n = 1'b1;
    spi_si   = 1'b0;
    hold_n   = 1'b1;
  end
  // data set while clock low, taken on the rise
  task automatic clk_bit(input logic b, input int half);
    spi_si = b;
    #(half);
    spi_clk = 1'b1;
    #(half);
    spi_clk = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] v, input int half);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(v[i], half);
    end
  endtask
  task automatic start();
    spi_cs_n = 1'b0;
    #24;
  endtask
  // released line shows the inverse of the last bit
  task automatic stop();
    #24;
    spi_cs_n = 1'b1;
    spi_si   = ~spi_si;
    #200;
  endtask
  task automatic pause();
    hold_n = 1'b0;
  endtask
  task automatic resume();
    hold_n = 1'b1;
  endtask
  task automatic dummies();
    repeat (3) send_byte(8'h00, 24);
  endtask
  // slow clock so the resynced output settles before sampling
  task automatic read_byte(output logic [7:0] v, input int half);
    for (int i = 7; i >= 0; i--) begin
      #(half);
      v[i] = spi_so_o;
      spi_clk = 1'b1;
      #(half);
      spi_clk = 1'b0;
    end
  endtask
endmodule

// File: verif/tb_serial_flash_command_decoder.sv
// self-checking bench for the instruction front end
// assumes the host model drives the link; clk_sys at 25 MHz
`timescale 1ns/1ps
module tb_serial_flash_command_decoder;
  import sfcd_pkg::*;
  localparam int         WAKE_CYC = 40;
  localparam logic [7:0] SIG      = 8'hC3; // arbitrary value
  logic         clk_sys = 1'b0;
  logic         reset = 1'b1;
  logic         array_busy = 1'b0;
  logic         deep_power_down = 1'b0;
  logic         spi_clk;
  logic         spi_cs_n;
  logic         spi_si;
  logic         hold_n;
  logic         spi_so_o;
  logic         spi_so_oe_n;
  logic         write_busy_flag;
  logic         wake_done;
  logic         cmd_valid;
  logic         ready;
  logic         seen;
  sfcd_decode_t cmd_info;
  int           num_errors = 0;
  int           samples_checked = 0;
  always #20 clk_sys = ~clk_sys;
  sfcd_host_model host (
    .spi_clk  (spi_clk),
    .spi_cs_n (spi_cs_n),
    .spi_si   (spi_si),
    .hold_n   (hold_n),
    .spi_so_o (spi_so_o)
  );
  sfcd_top #(.SIGNATURE_BYTE(SIG), .WAKE_DELAY_CYCLES(WAKE_CYC)) dut (
    .clk_sys         (clk_sys),
    .reset           (reset),
    .spi_clk         (spi_clk),
    .spi_cs_n        (spi_cs_n),
    .spi_si          (spi_si),
    .hold_n          (hold_n),
    .array_busy      (array_busy),
    .deep_power_down (deep_power_down),
    .spi_so_o        (spi_so_o),
    .spi_so_oe_n     (spi_so_oe_n),
    .write_busy_flag (write_busy_flag),
    .wake_done       (wake_done),
    .cmd_valid       (cmd_valid),
    .cmd_info        (cmd_info),
    .ready           (ready)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      if (cmd_valid === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic frame(input logic [7:0] op);
    fork
      begin
        host.start();
        host.send_byte(op, 24);
        host.stop();
      end
      watch(30);
    join
  endtask
  task automatic t_reset();
    chk(spi_so_oe_n, 1'b1);
    chk(ready, 1'b1);
    chk(write_busy_flag, 1'b0);
    chk(cmd_valid, 1'b0);
  endtask
  // every supported opcode, both suspend and resume codes
  task automatic t_decode();
    logic [7:0] ops [18] = '{8'hAB, 8'h9F, 8'h90, 8'h03, 8'h0B, 8'h3B, 8'hBB, 8'h6B,
      8'hEB, 8'h02, 8'hA2, 8'h32, 8'h75, 8'hB0, 8'h7A, 8'h30, 8'hB1, 8'h4B};
    sfcd_cmd_t  cmds [18] = '{SFCD_CMD_SIG, SFCD_CMD_STD_ID, SFCD_CMD_MAKER,
      SFCD_CMD_READ, SFCD_CMD_FAST, SFCD_CMD_FR2_OUT, SFCD_CMD_FR2_IO, SFCD_CMD_FR4_OUT,
      SFCD_CMD_FR4_IO, SFCD_CMD_PAGE_WR, SFCD_CMD_PAGE_WR2, SFCD_CMD_PAGE_WR4,
      SFCD_CMD_SUSPEND, SFCD_CMD_SUSPEND, SFCD_CMD_RESUME, SFCD_CMD_RESUME,
      SFCD_CMD_OTP_WR, SFCD_CMD_OTP_RD};
    // zero marks a count left open
    logic [2:0] nb [18] = '{3'h4, 3'h1, 3'h4, 3'h4, 3'h5, 3'h5, 3'h3, 3'h5, 3'h2,
      3'h4, 3'h0, 3'h4, 3'h1, 3'h1, 3'h1, 3'h1, 3'h4, 3'h4};
    for (int i = 0; i < 18; i++) begin
      frame(ops[i]);
      chk(seen, 1'b1);
      chk(8'(cmd_info.cmd), 8'(cmds[i]));
      if (nb[i] != 3'h0) chk(cmd_info.cmd_bytes, nb[i]);
      chk(cmd_info.slow_clock, (ops[i] == 8'h03 || ops[i] == 8'h4B));
      chk(cmd_info.has_data, (ops[i] == 8'h02 || ops[i] == 8'hA2 || ops[i] == 8'h32));
    end
  endtask
  task automatic t_unknown();
    frame(8'h06);
    chk(seen, 1'b0);
    frame(8'hFF);
    chk(seen, 1'b0);
  endtask
  // pause after four opcode bits, junk clocked meanwhile
  task automatic t_hold();
    fork
      begin
        host.start();
        for (int i = 0; i < 4; i++) host.clk_bit(i == 0 || i == 3, 24);
        host.pause();
        repeat (5) host.clk_bit(1'b0, 24);
        chk(spi_so_oe_n, 1'b1);
        host.resume();
        host.send_byte(8'hF0, 24);
        host.stop();
      end
      watch(60);
    join
    chk(seen, 1'b1);
    chk(8'(cmd_info.cmd), 8'(SFCD_CMD_STD_ID));
  endtask
  task automatic t_sig();
    logic [7:0] v;
    host.start();
    host.send_byte(8'hAB, 24);
    host.dummies();
    host.read_byte(v, 200);
    chk(v, SIG);
    chk(spi_so_oe_n, 1'b0);
    host.pause();
    repeat (3) host.clk_bit(1'b1, 200);
    chk(spi_so_oe_n, 1'b1);
    host.resume();
    host.read_byte(v, 200);
    chk(v, SIG);
    host.read_byte(v, 200);
    chk(v, SIG);
    host.stop();
    chk(spi_so_oe_n, 1'b1);
  endtask
  task automatic t_busy();
    @(posedge clk_sys);
    #1;
    array_busy      = 1'b1;
    deep_power_down = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(write_busy_flag, 1'b1);
    frame(8'hAB);
    chk(seen, 1'b0);
    chk(ready, 1'b1);
    @(posedge clk_sys);
    #1;
    array_busy = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(write_busy_flag, 1'b0);
  endtask
  task automatic t_wake();
    int   cnt;
    int   pulses;
    logic done;
    cnt    = 0;
    pulses = 0;
    done   = 1'b0;
    fork
      begin
        host.start();
        host.send_byte(8'hAB, 24);
        host.stop();
        host.start();
        host.send_byte(8'h9F, 24);
        host.stop();
      end
      repeat (150) begin
        @(posedge clk_sys);
        #1;
        if (ready === 1'b0) cnt++;
        if (cmd_valid === 1'b1) pulses++;
        if (wake_done === 1'b1) done = 1'b1;
      end
    join
    chk(done, 1'b1);
    chk(cnt >= WAKE_CYC && cnt <= WAKE_CYC + 1, 1'b1);
    chk(8'(pulses), 8'h01);
    @(posedge clk_sys);
    #1;
    deep_power_down = 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    t_reset();
    t_decode();
    t_unknown();
    t_hold();
    t_sig();
    t_busy();
    t_wake();
    wrap_up();
  end
  initial begin
    #500_000;
    num_errors++;
    wrap_up();
  end
endmodule
